// ### rtl/scd_params.svh
// Opcodes, register addresses and field positions of the SPI command decoder.
`ifndef SCD_PARAMS_SVH
`define SCD_PARAMS_SVH

// ----------------------------------------------------------------
// Instruction bytes
// ----------------------------------------------------------------
`define SCD_OP_RESET 8'hc0
`define SCD_OP_READ 8'h03
`define SCD_OP_WRITE 8'h02
`define SCD_OP_BITMOD 8'h05
`define SCD_OP_STATUS 8'ha0
`define SCD_OP_RXSTAT 8'hb0
`define SCD_OP_RXRD_MASK 8'hf9
`define SCD_OP_RXRD_VAL 8'h90
`define SCD_OP_TXLD_MASK 8'hf8
`define SCD_OP_TXLD_VAL 8'h40
`define SCD_OP_RTS_MASK 8'hf8
`define SCD_OP_RTS_VAL 8'h80
`define SCD_TXLD_MAX 3'h5

// ----------------------------------------------------------------
// Register addresses and fields
// ----------------------------------------------------------------
`define SCD_ADDR_TRANSMIT_BUFFER_ZERO_CTRL 8'h30
`define SCD_ADDR_TRANSMIT_BUFFER_ZERO_ID 8'h31
`define SCD_ADDR_RECEIVE_BUFFER_ZERO_ID 8'h61
`define SCD_BUF_DATA_OFS 8'h05
`define SCD_ADDR_INTF 8'h2c
`define SCD_TRANSMIT_REQUEST_FLAG_BIT 3
`define SCD_MASK_ALL 8'hff
`define SCD_IDLE_BYTE 8'h00

`endif

// ### rtl/scd_pkg.sv
// Types shared by the SPI command decoder modules.
package scd_pkg;

	typedef enum logic [3:0] {
		ST_IDLE,
		ST_RD_ADDR,
		ST_RD_DATA,
		ST_WR_ADDR,
		ST_WR_DATA,
		ST_BM_ADDR,
		ST_BM_MASK,
		ST_BM_DATA,
		ST_STATUS,
		ST_RXSTAT,
		ST_IGNORE
	} scd_state_t;

endpackage

// ### rtl/scd_link_if.sv
// Byte-level link between the SPI shifter and the command decoder.
`timescale 1ns/100ps
interface scd_link_if;
	logic rxDone;
	logic [7:0] rxByte;
	logic txLoad;
	logic [7:0] txByte;
	logic frameStart;
	logic frameEnd;

	modport engine (output rxDone, output rxByte, output txLoad, output frameStart, output frameEnd,
		input txByte);
	modport decoder (input rxDone, input rxByte, input txLoad, input frameStart, input frameEnd,
		output txByte);
endinterface

// ### rtl/scd_spi_shifter.sv
// SPI pin synchroniser and byte shifter, modes 0,0 and 1,1.
`timescale 1ns/100ps
module scd_spi_shifter (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// SPI pins
	input wire logic sckPin,
	input wire logic csNPin,
	input wire logic siPin,
	// Byte link
	scd_link_if.engine link,
	// Serial output
	output logic so,
	output logic soEn
);

	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	logic sck1_q, sck2_q, sck3_q, csN1_q, csN2_q, csN3_q, si1_q, si2_q;

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			sck1_q <= 1'b0;
			sck2_q <= 1'b0;
			sck3_q <= 1'b0;
			csN1_q <= 1'b1;
			csN2_q <= 1'b1;
			csN3_q <= 1'b1;
			si1_q <= 1'b0;
			si2_q <= 1'b0;
		end
		else
		begin
			sck1_q <= sckPin;
			sck2_q <= sck1_q;
			sck3_q <= sck2_q;
			csN1_q <= csNPin;
			csN2_q <= csN1_q;
			csN3_q <= csN2_q;
			si1_q <= siPin;
			si2_q <= si1_q;
		end
	end

	logic sckRise, sckFall, csFall, csRise;
	assign sckRise = sck2_q & ~sck3_q & ~csN2_q;
	assign sckFall = ~sck2_q & sck3_q & ~csN2_q;
	assign csFall = ~csN2_q & csN3_q;
	assign csRise = csN2_q & ~csN3_q;

	// ----------------------------------------------------------------
	// Shift registers
	// ----------------------------------------------------------------
	logic [2:0] bitCnt_q, bitCnt_d;
	logic [7:0] rxSh_q, rxSh_d, txSh_q, txSh_d, rxByte_q, rxByte_d;
	logic so_q, so_d, rxDone_q, rxDone_d, txLoad_q, txLoad_d;

	always_comb
	begin
		bitCnt_d = bitCnt_q;
		rxSh_d = rxSh_q;
		txSh_d = txSh_q;
		rxByte_d = rxByte_q;
		so_d = so_q;
		rxDone_d = 1'b0;
		txLoad_d = 1'b0;
		// A byte cut short by a rising select never raises rxDone, so it is dropped.
		if (csFall)
			bitCnt_d = 3'h0;
		else
		begin
			if (sckRise)
			begin
				rxSh_d = {rxSh_q[6:0], si2_q};
				bitCnt_d = bitCnt_q + 3'h1;
				if (bitCnt_q == 3'h7)
				begin
					rxDone_d = 1'b1;
					rxByte_d = {rxSh_q[6:0], si2_q};
				end
			end
			if (sckFall)
			begin
				if (bitCnt_q == 3'h0)
				begin
					so_d = link.txByte[7];
					txSh_d = {link.txByte[6:0], 1'b0};
					txLoad_d = 1'b1;
				end
				else
				begin
					so_d = txSh_q[7];
					txSh_d = {txSh_q[6:0], 1'b0};
				end
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			bitCnt_q <= 3'h0;
			rxSh_q <= 8'h00;
			txSh_q <= 8'h00;
			rxByte_q <= 8'h00;
			so_q <= 1'b0;
			rxDone_q <= 1'b0;
			txLoad_q <= 1'b0;
			soEn <= 1'b0;
			link.frameStart <= 1'b0;
			link.frameEnd <= 1'b0;
		end
		else
		begin
			bitCnt_q <= bitCnt_d;
			rxSh_q <= rxSh_d;
			txSh_q <= txSh_d;
			rxByte_q <= rxByte_d;
			so_q <= so_d;
			rxDone_q <= rxDone_d;
			txLoad_q <= txLoad_d;
			soEn <= ~csN2_q;
			link.frameStart <= csFall;
			link.frameEnd <= csRise;
		end
	end

	assign so = so_q;
	assign link.rxDone = rxDone_q;
	assign link.rxByte = rxByte_q;
	assign link.txLoad = txLoad_q;

endmodule // scd_spi_shifter

// ### rtl/scd_spi_decoder.sv
// SPI instruction decoder of the CAN controller, top level.
`timescale 1ns/100ps
`include "scd_params.svh"
// ----------------------------------------------------------------
// ----------------------------------------------------------------
module scd_spi_decoder (
	// Clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// SPI pins
	input wire logic sckPin,
	input wire logic csNPin,
	input wire logic siPin,
	output logic so,
	output logic soEn,
	// Register file port
	output logic [7:0] regRdAddr,
	input wire logic [7:0] regRdData,
	output logic regWrEn,
	output logic [7:0] regWrAddr,
	output logic [7:0] regWrData,
	output logic [7:0] regWrMask,
	// Live status from the register file
	input wire logic [7:0] intFlags,
	input wire logic [2:0] txReqFlags,
	input wire logic [1:0] rxExtId,
	input wire logic [1:0] rxRemote,
	input wire logic [2:0] rxFilt0,
	input wire logic [2:0] rxFilt1,
	// Device reset request
	output logic resetReq
);

	scd_link_if link ();

	scd_spi_shifter i_scd_spi_shifter (
		.sys_clk(sys_clk),
		.rst(rst),
		.sckPin(sckPin),
		.csNPin(csNPin),
		.siPin(siPin),
		.link(link.engine),
		.so(so),
		.soEn(soEn)
	);

	// ----------------------------------------------------------------
	// Address helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] txBufAddr(input logic [2:0] sel);
		return `SCD_ADDR_TRANSMIT_BUFFER_ZERO_ID + {2'b00, sel[2:1], 4'h0} + (sel[0] ? `SCD_BUF_DATA_OFS : 8'h00);
	endfunction

	function automatic logic [7:0] rxBufAddr(input logic [1:0] sel);
		return `SCD_ADDR_RECEIVE_BUFFER_ZERO_ID + {3'b000, sel[1], 4'h0} + (sel[0] ? `SCD_BUF_DATA_OFS : 8'h00);
	endfunction

	function automatic logic [7:0] txCtrlAddr(input logic [1:0] idx);
		return `SCD_ADDR_TRANSMIT_BUFFER_ZERO_CTRL + {2'b00, idx, 4'h0};
	endfunction

	// Control and status registers accept masked updates; buffers do not.
	function automatic logic bitModOk(input logic [7:0] addr);
		return (addr == 8'h0c) || (addr == 8'h0d) || (addr[3:1] == 3'h7) ||
			(addr >= 8'h28 && addr <= 8'h2d) || (addr[3:0] == 4'h0 && addr >= 8'h30 && addr <= 8'h70);
	endfunction

	// ----------------------------------------------------------------
	// Poll bytes
	// ----------------------------------------------------------------
	logic [7:0] statusByte, rxStatByte;
	logic useBuf0;

	// Built from the live register contents, so a plain read sees the same bits.
	assign statusByte = {intFlags[4], txReqFlags[2], intFlags[3], txReqFlags[1],
		intFlags[2], txReqFlags[0], intFlags[1], intFlags[0]};
	assign useBuf0 = intFlags[0];
	assign rxStatByte = {intFlags[1], intFlags[0], 1'b0,
		useBuf0 ? rxExtId[0] : rxExtId[1], useBuf0 ? rxRemote[0] : rxRemote[1],
		useBuf0 ? rxFilt0 : rxFilt1};

	// ----------------------------------------------------------------
	// Command sequencer
	// ----------------------------------------------------------------
	scd_pkg::scd_state_t state_q, state_d;
	logic [7:0] ptr_q, ptr_d, mask_q, mask_d;
	logic [2:0] txPend_q, txPend_d;
	logic rdClr_q, rdClr_d, rdBuf_q, rdBuf_d, resetReq_d;
	logic wrEn_d;
	logic [7:0] wrAddr_d, wrData_d, wrMask_d;
	logic [7:0] op;

	assign op = link.rxByte;

	always_comb
	begin
		state_d = state_q;
		ptr_d = ptr_q;
		mask_d = mask_q;
		txPend_d = txPend_q;
		rdClr_d = rdClr_q;
		rdBuf_d = rdBuf_q;
		resetReq_d = 1'b0;
		wrEn_d = 1'b0;
		wrAddr_d = regWrAddr;
		wrData_d = regWrData;
		wrMask_d = regWrMask;
		if (link.frameEnd)
		begin
			state_d = scd_pkg::ST_IDLE;
			rdClr_d = 1'b0;
			if (rdClr_q)
			begin
				wrEn_d = 1'b1;
				wrAddr_d = `SCD_ADDR_INTF;
				wrData_d = 8'h00;
				wrMask_d = {6'h00, rdBuf_q, ~rdBuf_q};
			end
		end
		else if (link.frameStart)
		begin
			state_d = scd_pkg::ST_IDLE;
			rdClr_d = 1'b0;
		end
		else
		begin
			unique case (state_q)
				scd_pkg::ST_IDLE:
					if (link.rxDone)
					begin
						state_d = scd_pkg::ST_IGNORE;
						if (op == `SCD_OP_RESET)
							resetReq_d = 1'b1;
						else if (op == `SCD_OP_READ)
							state_d = scd_pkg::ST_RD_ADDR;
						else if (op == `SCD_OP_WRITE)
							state_d = scd_pkg::ST_WR_ADDR;
						else if (op == `SCD_OP_BITMOD)
							state_d = scd_pkg::ST_BM_ADDR;
						else if (op == `SCD_OP_STATUS)
							state_d = scd_pkg::ST_STATUS;
						else if (op == `SCD_OP_RXSTAT)
							state_d = scd_pkg::ST_RXSTAT;
						else if ((op & `SCD_OP_RXRD_MASK) == `SCD_OP_RXRD_VAL)
						begin
							ptr_d = rxBufAddr(op[2:1]);
							rdClr_d = 1'b1;
							rdBuf_d = op[2];
							state_d = scd_pkg::ST_RD_DATA;
						end
						else if ((op & `SCD_OP_TXLD_MASK) == `SCD_OP_TXLD_VAL && op[2:0] <= `SCD_TXLD_MAX)
						begin
							ptr_d = txBufAddr(op[2:0]);
							state_d = scd_pkg::ST_WR_DATA;
						end
						else if ((op & `SCD_OP_RTS_MASK) == `SCD_OP_RTS_VAL)
							txPend_d = op[2:0];
					end
				scd_pkg::ST_RD_ADDR, scd_pkg::ST_WR_ADDR, scd_pkg::ST_BM_ADDR:
					if (link.rxDone)
					begin
						ptr_d = op;
						state_d = (state_q == scd_pkg::ST_RD_ADDR) ? scd_pkg::ST_RD_DATA :
							(state_q == scd_pkg::ST_WR_ADDR) ? scd_pkg::ST_WR_DATA : scd_pkg::ST_BM_MASK;
					end
				scd_pkg::ST_RD_DATA:
					if (link.txLoad)
						ptr_d = ptr_q + 8'h01;
				scd_pkg::ST_WR_DATA:
					if (link.rxDone)
					begin
						wrEn_d = 1'b1;
						wrAddr_d = ptr_q;
						wrData_d = op;
						wrMask_d = `SCD_MASK_ALL;
						ptr_d = ptr_q + 8'h01;
					end
				scd_pkg::ST_BM_MASK:
					if (link.rxDone)
					begin
						mask_d = op;
						state_d = scd_pkg::ST_BM_DATA;
					end
				scd_pkg::ST_BM_DATA:
					if (link.rxDone)
					begin
						wrEn_d = 1'b1;
						wrAddr_d = ptr_q;
						wrData_d = op;
						wrMask_d = bitModOk(ptr_q) ? mask_q : `SCD_MASK_ALL;
						state_d = scd_pkg::ST_IGNORE;
					end
				scd_pkg::ST_STATUS, scd_pkg::ST_RXSTAT, scd_pkg::ST_IGNORE: ;
			endcase
		end
		// Requests drain one per cycle, lowest buffer first, when the port is free.
		if (!wrEn_d && txPend_q != 3'h0)
		begin
			wrEn_d = 1'b1;
			wrData_d = 8'h01 << `SCD_TRANSMIT_REQUEST_FLAG_BIT;
			wrMask_d = 8'h01 << `SCD_TRANSMIT_REQUEST_FLAG_BIT;
			if (txPend_q[0])
			begin
				wrAddr_d = txCtrlAddr(2'd0);
				txPend_d[0] = 1'b0;
			end
			else if (txPend_q[1])
			begin
				wrAddr_d = txCtrlAddr(2'd1);
				txPend_d[1] = 1'b0;
			end
			else
			begin
				wrAddr_d = txCtrlAddr(2'd2);
				txPend_d[2] = 1'b0;
			end
		end
	end

	always_ff @(posedge sys_clk)
	begin
		if (rst)
		begin
			state_q <= scd_pkg::ST_IDLE;
			ptr_q <= 8'h00;
			mask_q <= 8'h00;
			txPend_q <= 3'h0;
			rdClr_q <= 1'b0;
			rdBuf_q <= 1'b0;
			resetReq <= 1'b0;
			regWrEn <= 1'b0;
			regWrAddr <= 8'h00;
			regWrData <= 8'h00;
			regWrMask <= 8'h00;
		end
		else
		begin
			state_q <= state_d;
			ptr_q <= ptr_d;
			mask_q <= mask_d;
			txPend_q <= txPend_d;
			rdClr_q <= rdClr_d;
			rdBuf_q <= rdBuf_d;
			resetReq <= resetReq_d;
			regWrEn <= wrEn_d;
			regWrAddr <= wrAddr_d;
			regWrData <= wrData_d;
			regWrMask <= wrMask_d;
		end
	end

	assign regRdAddr = ptr_q;

	// ----------------------------------------------------------------
	// Output byte selection
	// ----------------------------------------------------------------
	always_comb
	begin
		unique case (state_q)
			scd_pkg::ST_RD_DATA: link.txByte = regRdData;
			scd_pkg::ST_STATUS: link.txByte = statusByte;
			scd_pkg::ST_RXSTAT: link.txByte = rxStatByte;
			default: link.txByte = `SCD_IDLE_BYTE;
		endcase
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (rst);

	logic opTaken;
	assign opTaken = link.rxDone && state_q == scd_pkg::ST_IDLE && !link.frameEnd && !link.frameStart;

	a_load_tx_ptr: assert property (opTaken && op == 8'h42 |=> ptr_q == 8'h41)
		else $error("transmit load pointer wrong");
	a_rts_two_bufs: assert property (opTaken && op == 8'h85 |=> ##1 regWrEn &&
		regWrAddr == 8'h30 && regWrMask == 8'h08 && regWrData == 8'h08 ##1 regWrEn && regWrAddr == 8'h50)
		else $error("request-to-send writes wrong");
	a_rts_empty: assert property (opTaken && op == 8'h80 |=> txPend_q == 3'h0 ##1 !regWrEn)
		else $error("empty request-to-send acted");
	a_reset_pulse: assert property (opTaken && op == `SCD_OP_RESET |=> resetReq ##1 !resetReq)
		else $error("reset command pulse wrong");
	a_fast_rd_ptr: assert property (opTaken && op == 8'h94 |=> ptr_q == 8'h71 &&
		state_q == scd_pkg::ST_RD_DATA)
		else $error("fast receive read pointer wrong");
	a_flag_clear: assert property (link.frameEnd && rdClr_q && rdBuf_q |=> regWrEn &&
		regWrAddr == 8'h2c && regWrMask == 8'h02 && regWrData == 8'h00)
		else $error("receive flag not cleared");
	a_write_commit: assert property (link.rxDone && state_q == scd_pkg::ST_WR_DATA && !link.frameEnd |=>
		regWrEn && regWrAddr == $past(ptr_q) && regWrData == $past(op) && ptr_q == $past(ptr_q) + 8'h01)
		else $error("data byte not committed");
	a_bm_full_mask: assert property (link.rxDone && state_q == scd_pkg::ST_BM_DATA && !link.frameEnd &&
		(ptr_q[7:3] == 5'h04 || (ptr_q[7:4] == 4'h3 && ptr_q[3:1] != 3'h7 && ptr_q[3:0] != 4'h0)) |=> regWrMask == 8'hff)
		else $error("mask not forced");
	a_read_advance: assert property (link.txLoad && state_q == scd_pkg::ST_RD_DATA && !link.frameEnd |=>
		ptr_q == $past(ptr_q) + 8'h01)
		else $error("read pointer did not advance");
	a_unknown_quiet: assert property (state_q == scd_pkg::ST_IGNORE && txPend_q == 3'h0 &&
		!link.frameEnd |=> !regWrEn)
		else $error("ignored command wrote");

endmodule // scd_spi_decoder

// ### test/scd_host_model.sv
// Host SPI master model that drives the decoder pins in modes 0,0 and 1,1.
`timescale 1ns/100ps
module scd_host_model (
	// Clock
	input wire logic sys_clk,
	// SPI pins
	output logic sckPin,
	output logic csNPin,
	output logic siPin,
	input wire logic so
);
	// ----------------------------------------------------------------
	// Host behaviour
	// ----------------------------------------------------------------
	// Half an SCK period in system clocks; the decoder needs three at least, so eight leaves margin for sync lag.
	localparam int HALF = 8;
	logic cpol = 1'b0;
	initial
	begin
		sckPin = 1'b0;
		csNPin = 1'b1;
		siPin = 1'b0;
	end
	task automatic tick(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask
	task automatic sel();
		tick(1);
		sckPin = cpol;
		tick(HALF);
		csNPin = 1'b0;
		tick(HALF);
	endtask
	task automatic desel();
		tick(HALF);
		csNPin = 1'b1;
		// A released data line must not keep showing its last bit.
		siPin = ~siPin;
		tick(HALF);
	endtask
	task automatic xbit(input logic b, output logic r);
		if (cpol)
			sckPin = 1'b0;
		siPin = b;
		tick(HALF);
		sckPin = 1'b1;
		r = so;
		tick(HALF);
		if (!cpol)
			sckPin = 1'b0;
	endtask
	task automatic xfer(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--)
			xbit(tx[i], rx[i]);
	endtask
endmodule // scd_host_model

// ### test/scd_spi_decoder_bench.sv
// Self-checking bench of the SPI command decoder with a behavioural register file.
`timescale 1ns/100ps
module scd_spi_decoder_bench;
	// ----------------------------------------------------------------
	// Signals and register file
	// ----------------------------------------------------------------
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic sckPin, csNPin, siPin, so, soEn, regWrEn, resetReq, pb;
	logic [7:0] regRdAddr, regRdData, regWrAddr, regWrData, regWrMask, intFlags, rv;
	logic [2:0] txReqFlags;
	logic [1:0] rxExtId = 2'b01;
	logic [1:0] rxRemote = 2'b10;
	logic [2:0] rxFilt0 = 3'h6;
	logic [2:0] rxFilt1 = 3'h3;
	logic [7:0] regs [256];
	logic [7:0] rdQ [$];
	logic [7:0] rxExp [4] = '{8'h0b, 8'h56, 8'h8b, 8'hd6};
	logic [7:0] txAddr [6] = '{8'h31, 8'h36, 8'h41, 8'h46, 8'h51, 8'h56};
	logic [7:0] wrExp [4] = '{8'ha5, 8'h3c, 8'h11, 8'h00};
	int n_mismatch = 0;
	int n_compared = 0;
	int cycles = 0;
	int nReset = 0;

	always #10 sys_clk = ~sys_clk;
	assign regRdData = regs[regRdAddr];
	assign intFlags = regs[8'h2c];
	assign txReqFlags = {regs[8'h50][3], regs[8'h40][3], regs[8'h30][3]};

	always @(posedge sys_clk)
	begin
		cycles <= cycles + 1;
		if (regWrEn)
			regs[regWrAddr] <= (regs[regWrAddr] & ~regWrMask) | (regWrData & regWrMask);
		if (resetReq)
			nReset <= nReset + 1;
		// The whole sequence needs about eleven thousand cycles.
		if (cycles == 30000)
		begin
			n_mismatch++;
			report_and_stop();
		end
	end

	scd_spi_decoder i_scd_spi_decoder (.sys_clk(sys_clk), .rst(rst), .sckPin(sckPin), .csNPin(csNPin),
		.siPin(siPin), .so(so), .soEn(soEn), .regRdAddr(regRdAddr), .regRdData(regRdData), .regWrEn(regWrEn),
		.regWrAddr(regWrAddr), .regWrData(regWrData), .regWrMask(regWrMask), .intFlags(intFlags),
		.txReqFlags(txReqFlags), .rxExtId(rxExtId), .rxRemote(rxRemote), .rxFilt0(rxFilt0), .rxFilt1(rxFilt1),
		.resetReq(resetReq));
	scd_host_model i_scd_host_model (.sys_clk(sys_clk), .sckPin(sckPin), .csNPin(csNPin), .siPin(siPin),
		.so(so));

	// ----------------------------------------------------------------
	// Tasks
	// ----------------------------------------------------------------
	task report_and_stop();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	task chk8(input logic [7:0] got, input logic [7:0] exp);
		n_compared++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task frame(input logic [7:0] tx [$], input int nRd);
		logic [7:0] r;
		rdQ.delete();
		i_scd_host_model.sel();
		chk8({7'h00, soEn}, 8'h01);
		foreach (tx[i])
			i_scd_host_model.xfer(tx[i], r);
		repeat (nRd)
		begin
			i_scd_host_model.xfer(8'h00, r);
			rdQ.push_back(r);
		end
		i_scd_host_model.desel();
		chk8({7'h00, soEn}, 8'h00);
	endtask
	task rd(input logic [7:0] a, input logic [7:0] exp);
		frame('{8'h03, a}, 1);
		chk8(rdQ[0], exp);
	endtask

	// ----------------------------------------------------------------
	// Tests
	// ----------------------------------------------------------------
	initial
	begin
		foreach (regs[i])
			regs[i] = 8'h00;
		repeat (20) @(posedge sys_clk);
		#1;
		rst = 1'b0;
		frame('{8'h02, 8'h20, 8'ha5, 8'h3c}, 0);
		i_scd_host_model.sel();
		i_scd_host_model.xfer(8'h02, rv);
		i_scd_host_model.xfer(8'h22, rv);
		i_scd_host_model.xfer(8'h11, rv);
		repeat (4) i_scd_host_model.xbit(1'b1, pb);
		i_scd_host_model.desel();
		frame('{8'h03, 8'h20}, 4);
		for (int i = 0; i < 4; i++)
			chk8(rdQ[i], wrExp[i]);
		$display("test write_read done");
		frame('{8'h02, 8'h2b, 8'hf0}, 0);
		frame('{8'h05, 8'h2b, 8'h3c, 8'haa}, 0);
		rd(8'h2b, 8'he8);
		frame('{8'h05, 8'h20, 8'h0f, 8'h5a}, 0);
		rd(8'h20, 8'h5a);
		$display("test masked_update done");
		frame('{8'h80}, 0);
		chk8({5'h00, txReqFlags}, 8'h00);
		frame('{8'h85}, 0);
		chk8({5'h00, txReqFlags}, 8'h05);
		chk8(regs[8'h30], 8'h08);
		regs[8'h2c] = 8'h15;
		frame('{8'ha0}, 2);
		chk8(rdQ[0], 8'hcd);
		chk8(rdQ[1], 8'hcd);
		rd(8'h2c, 8'h15);
		rd(8'h50, 8'h08);
		$display("test request_status done");
		for (int f = 0; f < 4; f++)
		begin
			regs[8'h2c] = {6'h00, f[1:0]};
			frame('{8'hb0}, 2);
			chk8(rdQ[0], rxExp[f]);
			chk8(rdQ[1], rxExp[f]);
		end
		$display("test receive_status done");
		regs[8'h66] = 8'h77;
		regs[8'h71] = 8'h44;
		regs[8'h2c] = 8'h03;
		frame('{8'h92}, 1);
		chk8(rdQ[0], 8'h77);
		chk8(regs[8'h2c], 8'h02);
		frame('{8'h94}, 1);
		chk8(rdQ[0], 8'h44);
		chk8(regs[8'h2c], 8'h00);
		$display("test fast_read done");
		for (int i = 0; i < 6; i++)
		begin
			frame('{8'h40 + i[7:0], 8'h60 + i[7:0]}, 0);
			chk8(regs[txAddr[i]], 8'h60 + i[7:0]);
		end
		frame('{8'hff, 8'h02, 8'h20, 8'h99}, 0);
		chk8(regs[8'h20], 8'h5a);
		frame('{8'hc0}, 0);
		chk8(nReset[7:0], 8'h01);
		// The surrounding device answers the reset request by pulsing the block's own reset.
		rst = 1'b1;
		repeat (4) @(posedge sys_clk);
		#1;
		chk8({5'h00, soEn, regWrEn, resetReq}, 8'h00);
		rst = 1'b0;
		$display("test load_unknown_reset done");
		i_scd_host_model.cpol = 1'b1;
		rd(8'h20, 8'h5a);
		$display("test mode_11 done");
		report_and_stop();
	end
endmodule // scd_spi_decoder_bench
